// ### src/card_config_host.sv
`timescale 1ns/1ps
module card_config_host
    import card_cfg_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Card pins
    output logic card_reg_n,
    output logic card_ce1_n,
    output logic card_ce2_n,
    output logic card_oe_n,
    output logic card_we_n,
    output logic [10:0] card_addr,
    output logic [7:0] card_data_out,
    input wire logic [7:0] card_data_in,
    output logic card_data_oe_n,
    input wire logic card_ready,
    input wire logic card_status_change_n
);

    typedef enum logic [7:0] {
        M_IDLE = 8'b0000_0001,
        M_RAW = 8'b0000_0010,
        M_SOCK = 8'b0000_0100,
        M_OPT = 8'b0000_1000,
        M_CS = 8'b0001_0000,
        M_SRST_SET = 8'b0010_0000,
        M_SRST_CLR = 8'b0100_0000,
        M_WAIT_RDY = 8'b1000_0000
    } main_state_type;

    card_access_if acc ();

    card_access_engine #(
        .SETUP_CYCLES(SETUP_CYCLES),
        .STROBE_CYCLES(STROBE_CYCLES),
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .acc(acc),
        .card_reg_n(card_reg_n),
        .card_ce1_n(card_ce1_n),
        .card_ce2_n(card_ce2_n),
        .card_oe_n(card_oe_n),
        .card_we_n(card_we_n),
        .card_addr(card_addr),
        .card_data_out(card_data_out),
        .card_data_in(card_data_in),
        .card_data_oe_n(card_data_oe_n)
    );

    main_state_type state_q, state_d;
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [10:0] setup_q;
    logic raw_write_q;
    logic [1:0] raw_index_q;
    logic [7:0] raw_data_q, last_rdata_q;
    logic pend_q, done_q, configured_q, sock_done_q;

    // Bus decode
    logic do_write, do_read, wr_ctrl, wr_setup, wr_status, wr_hit, rd_hit;
    logic go_config, go_srst, go_raw, busy, step_end, seq_end;
    logic [31:0] status_word, read_word;

    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign do_read = s_axi_arvalid && !rvalid_q;
    assign wr_ctrl = do_write && (awaddr_q == REG_CTRL) && wstrb_q[0];
    assign wr_setup = do_write && (awaddr_q == REG_SETUP);
    assign wr_status = do_write && (awaddr_q == REG_STATUS) && wstrb_q[0];
    assign wr_hit = (awaddr_q == REG_CTRL) || (awaddr_q == REG_SETUP) || (awaddr_q == REG_STATUS);
    assign rd_hit = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_SETUP) || (s_axi_araddr == REG_STATUS);

    // A start while busy is dropped rather than queued
    assign busy = (state_q != M_IDLE);
    assign go_config = wr_ctrl && !busy && wdata_q[CTRL_GO_CONFIG];
    assign go_srst = wr_ctrl && !busy && wdata_q[CTRL_GO_SOFT_RESET] && !wdata_q[CTRL_GO_CONFIG];
    assign go_raw = wr_ctrl && !busy && wdata_q[CTRL_GO_RAW] && !go_config && !go_srst;
    assign step_end = pend_q && acc.done;
    assign seq_end = (step_end && ((state_q == M_RAW) || (state_q == M_CS)))
        || ((state_q == M_WAIT_RDY) && card_ready);

    assign status_word = {16'h0000, last_rdata_q, 3'b000, !card_status_change_n, card_ready,
        configured_q, done_q, busy};
    assign read_word = (s_axi_araddr == REG_CTRL) ? {16'h0000, raw_data_q, 2'b00, raw_index_q, raw_write_q, 3'b000}
        : (s_axi_araddr == REG_SETUP) ? {21'h000000, setup_q}
        : (s_axi_araddr == REG_STATUS) ? status_word : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            M_IDLE: begin
                if (go_config) state_d = M_SOCK;
                else if (go_srst) state_d = M_SRST_SET;
                else if (go_raw) state_d = M_RAW;
            end
            M_RAW: if (step_end) state_d = M_IDLE;
            M_SOCK: if (step_end) state_d = M_OPT;
            M_OPT: if (step_end) state_d = M_CS;
            M_CS: if (step_end) state_d = M_IDLE;
            M_SRST_SET: if (step_end) state_d = M_SRST_CLR;
            M_SRST_CLR: if (step_end) state_d = M_WAIT_RDY;
            M_WAIT_RDY: if (card_ready) state_d = M_IDLE;
        endcase
    end

    // Request payload per step; fixed bits forced so the card never sees stray ones
    logic [7:0] opt_byte, cs_byte, sock_byte, req_byte;
    logic [1:0] req_index;
    assign opt_byte = {1'b0, setup_q[SETUP_STYLE], setup_q[MODE_W-1:0]};
    assign cs_byte = {1'b0, setup_q[SETUP_SIGEN], setup_q[SETUP_NARROW], 2'b00, setup_q[SETUP_PWD], 2'b00};
    assign sock_byte = {3'b000, setup_q[SETUP_COPY], 4'h0};
    assign req_index = (state_q == M_RAW) ? raw_index_q
        : (state_q == M_SOCK) ? IDX_SOCKET_COPY
        : (state_q == M_CS) ? IDX_CONFIG_STATUS : IDX_CONFIG_OPTION;
    assign req_byte = (state_q == M_RAW) ? raw_data_q
        : (state_q == M_SOCK) ? sock_byte
        : (state_q == M_OPT) ? opt_byte
        : (state_q == M_CS) ? cs_byte
        : (state_q == M_SRST_SET) ? SOFT_RESET_VALUE : BYTE_ZERO;

    assign acc.valid = !pend_q && (state_q != M_IDLE) && (state_q != M_WAIT_RDY);
    assign acc.write = (state_q == M_RAW) ? raw_write_q : 1'b1;
    assign acc.index = req_index;
    assign acc.wdata = apply_mask(req_index, req_byte);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= M_IDLE;
            pend_q <= 1'b0;
            sock_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (acc.valid && acc.ready) pend_q <= 1'b1;
            else if (acc.done) pend_q <= 1'b0;
            if (state_q == M_IDLE) sock_done_q <= 1'b0;
            else if (state_q == M_SOCK && step_end) sock_done_q <= 1'b1;
        end
    end

    // Sequence results; done sets over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            configured_q <= 1'b0;
            last_rdata_q <= '0;
        end else begin
            if (seq_end) done_q <= 1'b1;
            else if (wr_status && wdata_q[STAT_DONE]) done_q <= 1'b0;
            if (state_q == M_CS && step_end) configured_q <= 1'b1;
            else if (go_srst) configured_q <= 1'b0;
            if (state_q == M_RAW && step_end && !raw_write_q) last_rdata_q <= acc.rdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_q <= SETUP_RESET;
            raw_write_q <= 1'b0;
            raw_index_q <= '0;
            raw_data_q <= '0;
        end else begin
            if (wr_setup && wstrb_q[0]) setup_q[7:0] <= wdata_q[7:0];
            if (wr_setup && wstrb_q[1]) setup_q[10:8] <= wdata_q[10:8];
            if (wr_ctrl && !busy) begin
                raw_write_q <= wdata_q[CTRL_RAW_WRITE];
                raw_index_q <= wdata_q[CTRL_RAW_INDEX_LSB +: 2];
            end
            if (do_write && (awaddr_q == REG_CTRL) && wstrb_q[1] && !busy) begin
                raw_data_q <= wdata_q[CTRL_RAW_DATA_LSB +: 8];
            end
        end
    end

    // AXI4-Lite slave
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (do_read) begin
                rvalid_q <= 1'b1;
                rdata_q <= read_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sock_step;
        (state_q == M_SOCK) ##1 (state_q == M_OPT);
    endsequence

    property p_order;
        (state_q == M_OPT) && acc.valid |-> sock_done_q;
    endproperty
    a_order: assert property (p_order) else $error("option written before socket register");

    property p_copy;
        (state_q == M_SOCK) && acc.valid |-> acc.wdata == (8'(setup_q[SETUP_COPY]) << COPY_NUMBER_BIT);
    endproperty
    a_copy: assert property (p_copy) else $error("copy number not at bit four");

    property p_narrow;
        (state_q == M_CS) && acc.valid |-> acc.wdata[NARROW_BUS_BIT] == setup_q[SETUP_NARROW];
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow bus bit lost");

    property p_fixed_bits;
        acc.valid && (acc.index == IDX_PIN_REPLACE) |-> (acc.wdata & ~MASK_PIN_REPLACE) == FIXED_PIN_REPLACE;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed pin replacement bits wrong");

    property p_cs_zero_bits;
        acc.valid && (acc.index == IDX_CONFIG_STATUS) |-> (acc.wdata & ~MASK_CONFIG_STATUS) == BYTE_ZERO;
    endproperty
    a_cs_zero_bits: assert property (p_cs_zero_bits) else $error("read-only status bits written");

    property p_srst_release;
        (state_q == M_SRST_SET) && step_end |=> (state_q == M_SRST_CLR) && acc.valid && acc.wdata == BYTE_ZERO;
    endproperty
    a_srst_release: assert property (p_srst_release) else $error("soft reset not released");

    property p_reconfig;
        go_srst |=> !configured_q && (state_q == M_SRST_SET);
    endproperty
    a_reconfig: assert property (p_reconfig) else $error("configured kept over card reset");

    property p_sock_then_opt;
        s_sock_step |-> acc.valid && acc.index == IDX_CONFIG_OPTION;
    endproperty
    a_sock_then_opt: assert property (p_sock_then_opt) else $error("option step not next");

    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

endmodule

// ### src/card_cfg_pkg.sv
package card_cfg_pkg;

    // Card attribute-space register addresses
    localparam logic [10:0] CARD_ADDR_CONFIG_OPTION = 11'h200;
    localparam logic [10:0] CARD_ADDR_CONFIG_STATUS = 11'h202;
    localparam logic [10:0] CARD_ADDR_PIN_REPLACE = 11'h204;
    localparam logic [10:0] CARD_ADDR_SOCKET_COPY = 11'h206;

    // Card register index
    localparam logic [1:0] IDX_CONFIG_OPTION = 2'h0;
    localparam logic [1:0] IDX_CONFIG_STATUS = 2'h1;
    localparam logic [1:0] IDX_PIN_REPLACE = 2'h2;
    localparam logic [1:0] IDX_SOCKET_COPY = 2'h3;

    // Card register fields
    localparam int SOFT_RESET_BIT = 7;
    localparam int INTERRUPT_STYLE_BIT = 6;
    localparam int MODE_W = 6;
    localparam int CHANGED_FLAG_BIT = 7;
    localparam int CHANGE_SIGNAL_EN_BIT = 6;
    localparam int NARROW_BUS_BIT = 5;
    localparam int POWER_DOWN_BIT = 2;
    localparam int INTERRUPT_PENDING_BIT = 1;
    localparam int COPY_NUMBER_BIT = 4;

    // Writable bits and fixed-one bits per card register
    localparam logic [7:0] MASK_CONFIG_OPTION = 8'hFF;
    localparam logic [7:0] MASK_CONFIG_STATUS = 8'h64;
    localparam logic [7:0] MASK_PIN_REPLACE = 8'h22;
    localparam logic [7:0] MASK_SOCKET_COPY = 8'h10;
    localparam logic [7:0] FIXED_PIN_REPLACE = 8'h0C;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] SOFT_RESET_VALUE = 8'h80;

    // Own AXI register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SETUP = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // Control register bits
    localparam int CTRL_GO_CONFIG = 0;
    localparam int CTRL_GO_SOFT_RESET = 1;
    localparam int CTRL_GO_RAW = 2;
    localparam int CTRL_RAW_WRITE = 3;
    localparam int CTRL_RAW_INDEX_LSB = 4;
    localparam int CTRL_RAW_DATA_LSB = 8;

    // Setup register bits
    localparam int SETUP_STYLE = 6;
    localparam int SETUP_SIGEN = 7;
    localparam int SETUP_NARROW = 8;
    localparam int SETUP_PWD = 9;
    localparam int SETUP_COPY = 10;
    localparam logic [10:0] SETUP_RESET = 11'h000;

    // Status register bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_CONFIGURED = 2;
    localparam int STAT_READY = 3;
    localparam int STAT_CHANGE = 4;
    localparam int STAT_RDATA_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Pin timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_SETUP_NS = 30;
    localparam int T_STROBE_NS = 300;
    localparam int T_HOLD_NS = 30;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    function automatic logic [10:0] card_addr(input logic [1:0] idx);
        card_addr = CARD_ADDR_CONFIG_OPTION + {8'h00, idx, 1'b0};
    endfunction

    function automatic logic [7:0] apply_mask(input logic [1:0] idx, input logic [7:0] d);
        logic [7:0] m;
        m = MASK_CONFIG_OPTION;
        unique case (idx)
            IDX_CONFIG_OPTION: m = MASK_CONFIG_OPTION;
            IDX_CONFIG_STATUS: m = MASK_CONFIG_STATUS;
            IDX_PIN_REPLACE: m = MASK_PIN_REPLACE;
            IDX_SOCKET_COPY: m = MASK_SOCKET_COPY;
        endcase
        apply_mask = (d & m) | ((idx == IDX_PIN_REPLACE) ? FIXED_PIN_REPLACE : BYTE_ZERO);
    endfunction

endpackage

// ### src/card_access_if.sv
`timescale 1ns/1ps
interface card_access_if;
    logic valid;
    logic ready;
    logic write;
    logic [1:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;

    modport master (output valid, output write, output index, output wdata, input ready, input rdata, input done);
    modport engine (input valid, input write, input index, input wdata, output ready, output rdata, output done);
endinterface

// ### src/card_access_engine.sv
`timescale 1ns/1ps
module card_access_engine
    import card_cfg_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request side
    card_access_if.engine acc,
    // Card pins
    output logic card_reg_n,
    output logic card_ce1_n,
    output logic card_ce2_n,
    output logic card_oe_n,
    output logic card_we_n,
    output logic [10:0] card_addr,
    output logic [7:0] card_data_out,
    input wire logic [7:0] card_data_in,
    output logic card_data_oe_n
);

    typedef enum logic [3:0] {
        E_IDLE = 4'b0001,
        E_SETUP = 4'b0010,
        E_STROBE = 4'b0100,
        E_HOLD = 4'b1000
    } eng_state_type;

    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam int STROBE_A = STROBE_CYCLES;

    eng_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q;
    logic wr_q;
    logic [10:0] addr_q;
    logic [7:0] dout_q, rdata_q;
    logic reg_n_q, ce1_n_q, oe_n_q, we_n_q, doe_n_q, done_q;
    logic take, phase_end;

    assign take = (state_q == E_IDLE) && acc.valid;
    assign phase_end = ((state_q == E_SETUP) && (cnt_q == SETUP_LAST))
        || ((state_q == E_STROBE) && (cnt_q == STROBE_LAST))
        || ((state_q == E_HOLD) && (cnt_q == HOLD_LAST));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            E_IDLE: if (take) state_d = E_SETUP;
            E_SETUP: if (phase_end) state_d = E_STROBE;
            E_STROBE: if (phase_end) state_d = E_HOLD;
            E_HOLD: if (phase_end) state_d = E_IDLE;
        endcase
    end

    // Byte access on the even lane, attribute space selected for the whole cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= E_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
            addr_q <= '0;
            dout_q <= '0;
            rdata_q <= '0;
            reg_n_q <= 1'b1;
            ce1_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            doe_n_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (phase_end || take) ? '0 : cnt_q + CNT_W'(1);
            done_q <= (state_q == E_HOLD) && phase_end;
            if (take) begin
                wr_q <= acc.write;
                addr_q <= card_cfg_pkg::card_addr(acc.index);
                dout_q <= acc.wdata;
                reg_n_q <= 1'b0;
                ce1_n_q <= 1'b0;
                doe_n_q <= !acc.write;
            end
            if (state_q == E_SETUP && phase_end) begin
                oe_n_q <= wr_q;
                we_n_q <= !wr_q;
            end
            if (state_q == E_STROBE && phase_end) begin
                oe_n_q <= 1'b1;
                we_n_q <= 1'b1;
                if (!wr_q) rdata_q <= card_data_in;
            end
            if (state_q == E_HOLD && phase_end) begin
                reg_n_q <= 1'b1;
                ce1_n_q <= 1'b1;
                doe_n_q <= 1'b1;
            end
        end
    end

    assign acc.ready = (state_q == E_IDLE);
    assign acc.rdata = rdata_q;
    assign acc.done = done_q;
    assign card_reg_n = reg_n_q;
    assign card_ce1_n = ce1_n_q;
    assign card_ce2_n = 1'b1;
    assign card_oe_n = oe_n_q;
    assign card_we_n = we_n_q;
    assign card_addr = addr_q;
    assign card_data_out = dout_q;
    assign card_data_oe_n = doe_n_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_attr_select;
        (!oe_n_q || !we_n_q) |-> (!reg_n_q && !ce1_n_q && !addr_q[0] && addr_q[9]);
    endproperty
    a_attr_select: assert property (p_attr_select) else $error("strobe outside attribute byte access");

    property p_strobe_width;
        $fell(oe_n_q && we_n_q) |-> ##STROBE_A $rose(oe_n_q && we_n_q);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

    property p_no_ide_oe;
        !oe_n_q |-> (state_q == E_STROBE) && !wr_q && doe_n_q;
    endproperty
    a_no_ide_oe: assert property (p_no_ide_oe) else $error("output enable low outside a read");

endmodule

// ### testbench/card_model.sv
`timescale 1ns/1ps
module card_model (
    // Card pins
    input wire logic aclk,
    input wire logic sel_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [10:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout = 8'h00,
    output logic ready,
    output logic chg_n
);
    logic [7:0] r [4] = '{8'h00, 8'h00, 8'h0C, 8'h00};
    logic [2:0] busy = 0;
    logic rdy_q = 1;
    wire [1:0] i = addr[2:1];
    // No internal request modelled, so pending stays zero
    wire [7:0] rv = i == 1 ? r[1] | {r[2][5], 7'h0} : i == 2 ? r[2] | {6'h0, ready, 1'b0} : r[i];
    assign ready = busy == 0 && !r[0][7];
    assign chg_n = !(r[2][5] && r[1][6] && r[0][5:0] != 0);
    always @(posedge aclk) begin
        rdy_q <= ready;
        // Released bus shows the inverse so stale data never matches
        dout <= !sel_n && !oe_n ? rv : ~dout;
        if (busy != 0) busy <= busy - 1;
        if (rdy_q != ready) r[2][5] <= 1;
        if (r[0][7]) r[1] <= 0;
        if (!sel_n && !we_n) begin
            if (i == 1 && din[2] != r[1][2]) busy <= 4;
            r[i] <= din & (i == 0 ? 8'hFF : i == 1 ? 8'h64 : i == 2 ? 8'h20 : 8'h10) | (i == 2 ? 8'h0C : 0);
        end
    end
endmodule

// ### testbench/card_config_host_bench.sv
`timescale 1ns/1ps
module card_config_host_bench;
    import card_cfg_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, e;
    logic card_reg_n, card_ce1_n, card_ce2_n, card_oe_n, card_we_n, card_data_oe_n, card_ready, card_status_change_n;
    logic [10:0] card_addr;
    logic [7:0] card_data_out, card_data_in;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    card_config_host #(.SETUP_CYCLES(1), .STROBE_CYCLES(2), .HOLD_CYCLES(1)) card_config_host_i (.*);
    card_model card_model_i (.aclk(aclk), .sel_n(card_reg_n | card_ce1_n), .oe_n(card_oe_n), .we_n(card_we_n),
        .addr(card_addr), .din(card_data_out), .dout(card_data_in), .ready(card_ready), .chg_n(card_status_change_n));
    always #2.5 aclk = ~aclk;
    // Data lines belong to the host during writes and to the card during reads
    always @(posedge aclk) begin
        if (aresetn && !card_we_n) cmp({card_data_oe_n, card_ce2_n}, 2'b01);
        if (aresetn && !card_oe_n) cmp({card_data_oe_n, card_ce2_n}, 2'b11);
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far above the hundred-odd cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    // Ready is sampled mid-cycle, acted on at the next rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] x);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        b = 0;
        while (!b) begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            e = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        cmp(e, x);
    endtask
    task automatic rd(input logic [3:0] a);
        logic r, ar;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        r = 0;
        while (!r) begin
            @(negedge aclk);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            v = s_axi_rdata;
            e = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
    endtask
    task automatic go(input logic [31:0] c);
        wr(REG_STATUS, 32'h2, RESP_OKAY);
        wr(REG_CTRL, c, RESP_OKAY);
        rd(REG_STATUS);
        while (!v[STAT_DONE]) rd(REG_STATUS);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        rd(REG_STATUS);
        cmp(v, 32'h8);
        rd(REG_SETUP);
        cmp(v, 32'h0);
        wr(4'hC, 32'h1, RESP_SLVERR);
        rd(4'hC);
        cmp(e, RESP_SLVERR);
        cmp(v, 32'h0);
        wr(REG_SETUP, 32'h7C2, RESP_OKAY);
        rd(REG_SETUP);
        cmp(v, 32'h7C2);
        go(32'h1);
        cmp(card_model_i.r[3], 32'h10);
        cmp(card_model_i.r[0], 32'h42);
        cmp(card_model_i.r[1], 32'h64);
        go(32'h24);
        cmp(v, 32'h2E1E);
        go(32'h2C);
        cmp(v & 32'hFF, 32'h0E);
        rd(REG_CTRL);
        cmp(v, 32'h28);
        go(32'h2);
        cmp(v & 32'hFF, 32'h0A);
        cmp(card_model_i.r[0], 32'h0);
        end_of_test;
    end
endmodule
